// file: logic/grm_pkg.sv
// Contract
// - Valid octet yields eight data bits to MAC
// - Extend code yields eight EXTEND bit equivalents
// - Receive codes: 0E false, 0F extend, 1F error
// - Transmit codes: 0F extend, 1F extend error
// - Carrier follows sense input, change indicated
// - Signal error follows collision, change indicated
// - Valid plus error forces frame check error
// - Extend error delivers data and frame error
// - Substitute delivered data so CRC fails
// - Corrupt frame: transmit error with enable
// - Corrupt extension: drive extend error code
// - Data-valid status derived, change indicated
// - Source continuous transmit clock for PHY
// - Receive lines captured on receive clock rise
// - Receive and transmit clocks are independent
// - Enable rises with first preamble octet
// - Enable falls before edge after last octet
package grm_pkg;
   // Receive and transmit octet codes while data-valid/enable low
   localparam logic [7:0] CODE_IDLE = 8'h00;
   localparam logic [7:0] CODE_FALSE_CARRIER = 8'h0e;
   localparam logic [7:0] CODE_EXTEND = 8'h0f;
   localparam logic [7:0] CODE_EXTEND_ERR = 8'h1f;
   // Mask used to corrupt delivered octets of a bad frame
   localparam logic [7:0] CORRUPT_MASK = 8'hff;
   // Octet width of the GMII data paths
   localparam int OCTET_W = 8;
   // Clock rates in MHz
   localparam int SYS_FREQ_MHZ = 50;
   localparam int GTX_FREQ_MHZ = 125;
   // Transmit clock half period in system cycles (rounded down, at least two)
   localparam int GTX_HALF_RAW = SYS_FREQ_MHZ / (2 * GTX_FREQ_MHZ);
   localparam int GTX_HALF_MIN = 2;
   localparam int GTX_HALF_DEF =
      (GTX_HALF_RAW < GTX_HALF_MIN) ? GTX_HALF_MIN : GTX_HALF_RAW;
   // Divider counter width
   localparam int DIV_W = 8;
   // Transmit framing states
   typedef enum logic [1:0]
   {
      TX_IDLE = 2'b00,
      TX_DATA = 2'b01,
      TX_EXT = 2'b10
   } grm_tx_state_t;
endpackage

// file: logic/grm_sync2.sv
module grm_sync2 #(
   parameter int W = 1
) (
   // Clock, reset and enable
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   // Asynchronous level in, synchronised level out
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   // First stage, read only by the second stage
   logic [W-1:0] meta_r;

   // Two flip-flop level synchroniser
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         meta_r <= '0;
         q <= '0;
      end
      else if (ce)
      begin
         meta_r <= d;
         q <= meta_r;
      end
   end
endmodule

// file: logic/grm_top.sv
module grm_top #(
   parameter int GTX_HALF = grm_pkg::GTX_HALF_DEF
) (
   // System clock, reset and clock enable
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic ce,
   // MAC transmit request side
   input wire logic macTxValid,
   input wire logic [7:0] macTxData,
   input wire logic macTxErr,
   input wire logic macTxExt,
   input wire logic macTxExtErr,
   output logic macTxAccept,
   // MAC receive indication side
   output logic macRxBitStb,
   output logic [7:0] macRxBits,
   output logic macRxExtend,
   output logic macRxFrameErr,
   output logic macRxFalseCarrier,
   output logic macDataValid,
   output logic macDataValidChg,
   output logic macCarrierOn,
   output logic macCarrierChg,
   output logic macSignalErr,
   output logic macSignalChg,
   // GMII transmit pins
   output logic gtxClk,
   output logic txEn,
   output logic txEr,
   output logic [7:0] txd,
   // GMII receive pins, timed by the PHY receive clock
   input wire logic rxClk,
   input wire logic rxDv,
   input wire logic rxEr,
   input wire logic [7:0] rxd,
   // GMII media status pins, asynchronous
   input wire logic crs,
   input wire logic col
);
   // Refuse a divider the framing handshake cannot serve
   if (GTX_HALF < grm_pkg::GTX_HALF_MIN || GTX_HALF > 255)
   begin : gBadHalf
      $error("grm_top: GTX_HALF out of range");
   end

   localparam logic [grm_pkg::DIV_W-1:0] HALF_LAST =
      grm_pkg::DIV_W'(GTX_HALF - 1);

   // Receive domain: registered pin samples
   logic rxDvQ_r;
   logic rxErQ_r;
   logic [7:0] rxdQ_r;
   // Receive domain: sticky frame error within one data-valid span
   logic rxErrStk_r;
   logic rxErrStk_nxt;
   // Receive domain: record handed to the system domain
   logic recData_r;
   logic recExt_r;
   logic recErr_r;
   logic recValid_r;
   logic recFalse_r;
   logic [7:0] recOctet_r;
   logic recTgl_r;

   // Capture receive lines on every rising receive clock edge
   always_ff @(posedge rxClk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rxDvQ_r <= 1'b0;
         rxErQ_r <= 1'b0;
         rxdQ_r <= 8'h00;
      end
      else
      begin
         rxDvQ_r <= rxDv;
         rxErQ_r <= rxEr;
         rxdQ_r <= rxd;
      end
   end

   // Decode of the captured octet while data-valid is low
   wire ctlCode = !rxDvQ_r && rxErQ_r;
   wire isExtend = ctlCode && (rxdQ_r == grm_pkg::CODE_EXTEND);
   wire isExtErr = ctlCode && (rxdQ_r == grm_pkg::CODE_EXTEND_ERR);
   wire isFalse = ctlCode &&
      (rxdQ_r == grm_pkg::CODE_FALSE_CARRIER);
   // Data-valid status: frame data, extend or extend error
   wire statValid = rxDvQ_r || isExtend || isExtErr;
   // Error events that must spoil the frame check
   wire dataErrEv = rxDvQ_r && rxErQ_r;
   wire errEv = dataErrEv || isExtErr;
   // Octets delivered as data bits: extend error, and extends of a
   // spoiled extension, reach the MAC as corrupted data, never EXTEND
   wire dataOctet = rxDvQ_r || isExtErr ||
      (isExtend && rxErrStk_nxt);
   // Sticky error: a new event wins over the end-of-span clear
   assign rxErrStk_nxt = errEv || (rxErrStk_r && statValid);
   // Corrupt every octet from the first error on so the CRC cannot match
   wire [7:0] subOctet = rxErrStk_nxt ?
      (rxdQ_r ^ grm_pkg::CORRUPT_MASK) : rxdQ_r;

   // Build one record per receive cycle and flip the toggle
   always_ff @(posedge rxClk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rxErrStk_r <= 1'b0;
         recData_r <= 1'b0;
         recExt_r <= 1'b0;
         recErr_r <= 1'b0;
         recValid_r <= 1'b0;
         recFalse_r <= 1'b0;
         recOctet_r <= 8'h00;
         recTgl_r <= 1'b0;
      end
      else
      begin
         rxErrStk_r <= rxErrStk_nxt;
         recData_r <= dataOctet;
         recExt_r <= isExtend && !rxErrStk_nxt;
         recErr_r <= rxErrStk_nxt;
         recValid_r <= statValid;
         recFalse_r <= isFalse;
         recOctet_r <= subOctet;
         recTgl_r <= !recTgl_r;
      end
   end

   // System domain: toggle and media status synchronisers
   logic tglSync;
   logic [1:0] mediaSync;
   logic tglSeen_r;

   // Record toggle crosses as a level, record words held meanwhile
   grm_sync2 #(
      .W(1)
   ) uTglSync (
      .clk(clk_sys),
      .rst_n(rst_n),
      .ce(ce),
      .d(recTgl_r),
      .q(tglSync)
   );

   // Carrier sense and collision into the MAC clock domain
   grm_sync2 #(
      .W(2)
   ) uMediaSync (
      .clk(clk_sys),
      .rst_n(rst_n),
      .ce(ce),
      .d({col, crs}),
      .q(mediaSync)
   );

   // A fresh record is waiting when the toggle has moved
   wire newRec = tglSync != tglSeen_r;
   wire crsS = mediaSync[0];
   wire colS = mediaSync[1];

   // Deliver receive records to the MAC
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         tglSeen_r <= 1'b0;
         macRxBitStb <= 1'b0;
         macRxBits <= 8'h00;
         macRxExtend <= 1'b0;
         macRxFrameErr <= 1'b0;
         macRxFalseCarrier <= 1'b0;
         macDataValid <= 1'b0;
         macDataValidChg <= 1'b0;
      end
      else if (ce)
      begin
         tglSeen_r <= tglSync;
         macRxBitStb <= newRec && recData_r;
         macRxExtend <= newRec && recExt_r;
         macRxFalseCarrier <= newRec && recFalse_r;
         macDataValidChg <= newRec &&
            (recValid_r != macDataValid);
         // Record fields are only read once the toggle has settled
         if (newRec)
         begin
            macRxBits <= recData_r ? recOctet_r : macRxBits;
            macRxFrameErr <= recErr_r;
            macDataValid <= recValid_r;
         end
      end
   end

   // Carrier and signal status with change strobes
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         macCarrierOn <= 1'b0;
         macCarrierChg <= 1'b0;
         macSignalErr <= 1'b0;
         macSignalChg <= 1'b0;
      end
      else if (ce)
      begin
         macCarrierOn <= crsS;
         macCarrierChg <= crsS != macCarrierOn;
         macSignalErr <= colS;
         macSignalChg <= colS != macSignalErr;
      end
   end

   // Transmit clock divider state
   logic [grm_pkg::DIV_W-1:0] halfCnt_r;
   logic [grm_pkg::DIV_W-1:0] halfCnt_nxt;
   // Transmit framing state
   grm_pkg::grm_tx_state_t txState_r;
   grm_pkg::grm_tx_state_t txState_nxt;
   // Next values of the transmit pins
   logic txEn_nxt;
   logic txEr_nxt;
   logic [7:0] txd_nxt;
   logic take_nxt;

   // Divider wrap; tick marks the falling transmit clock edge
   wire halfWrap = halfCnt_r == HALF_LAST;
   wire tick = halfWrap && gtxClk;
   assign halfCnt_nxt = halfWrap ? '0 : halfCnt_r + 1'b1;
   // Extension octet code, error variant on request
   wire [7:0] extCode = macTxExtErr ?
      grm_pkg::CODE_EXTEND_ERR : grm_pkg::CODE_EXTEND;

   // Framing decisions taken at each transmit period
   always_comb
   begin
      txState_nxt = txState_r;
      txEn_nxt = 1'b0;
      txEr_nxt = 1'b0;
      txd_nxt = grm_pkg::CODE_IDLE;
      take_nxt = 1'b0;
      case (txState_r)
         grm_pkg::TX_IDLE:
         begin
            // First octet of a frame raises enable with it
            if (macTxValid)
            begin
               txState_nxt = grm_pkg::TX_DATA;
               txEn_nxt = 1'b1;
               txEr_nxt = macTxErr;
               txd_nxt = macTxData;
               take_nxt = 1'b1;
            end
         end
         grm_pkg::TX_DATA:
         begin
            if (macTxValid)
            begin
               // Enable held for every octet of the frame
               txEn_nxt = 1'b1;
               txEr_nxt = macTxErr;
               txd_nxt = macTxData;
               take_nxt = 1'b1;
            end
            else if (macTxExt)
            begin
               // Extension follows the data directly
               txState_nxt = grm_pkg::TX_EXT;
               txEr_nxt = 1'b1;
               txd_nxt = extCode;
               take_nxt = 1'b1;
            end
            else
            begin
               // Frame over: enable drops at this falling edge
               txState_nxt = grm_pkg::TX_IDLE;
            end
         end
         grm_pkg::TX_EXT:
         begin
            if (macTxValid)
            begin
               // Next frame of a burst
               txState_nxt = grm_pkg::TX_DATA;
               txEn_nxt = 1'b1;
               txEr_nxt = macTxErr;
               txd_nxt = macTxData;
               take_nxt = 1'b1;
            end
            else if (macTxExt)
            begin
               txEr_nxt = 1'b1;
               txd_nxt = extCode;
               take_nxt = 1'b1;
            end
            else
            begin
               txState_nxt = grm_pkg::TX_IDLE;
            end
         end
         default:
         begin
            txState_nxt = grm_pkg::TX_IDLE;
         end
      endcase
   end

   // Transmit clock generation, free running from reset
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         halfCnt_r <= '0;
         gtxClk <= 1'b0;
      end
      else if (ce)
      begin
         halfCnt_r <= halfCnt_nxt;
         gtxClk <= halfWrap ? !gtxClk : gtxClk;
      end
   end

   // Transmit pins change only at the falling transmit clock edge,
   // so they stand still around the PHY's rising sample edge
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         txState_r <= grm_pkg::TX_IDLE;
         txEn <= 1'b0;
         txEr <= 1'b0;
         txd <= grm_pkg::CODE_IDLE;
         macTxAccept <= 1'b0;
      end
      else if (ce)
      begin
         macTxAccept <= tick && take_nxt;
         if (tick)
         begin
            txState_r <= txState_nxt;
            txEn <= txEn_nxt;
            txEr <= txEr_nxt;
            txd <= txd_nxt;
         end
      end
   end
endmodule

// file: verification/grm_props.sv
module grm_props #(
   parameter int GTX_HALF = 2
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // Status pins and results
   input wire logic crs,
   input wire logic col,
   input wire logic macCarrierOn,
   input wire logic macCarrierChg,
   input wire logic macSignalErr,
   input wire logic macSignalChg,
   input wire logic macDataValid,
   input wire logic macDataValidChg,
   input wire logic macRxBitStb,
   input wire logic macRxExtend,
   // Transmit side
   input wire logic macTxAccept,
   input wire logic gtxClk,
   input wire logic txEn,
   input wire logic txEr,
   input wire logic [7:0] txd
);
   // Cycles since reset release, saturating
   logic [2:0] upCnt_r;
   always_ff @(posedge clk_sys or negedge rst_n)
      if (!rst_n)
         upCnt_r <= 3'h0;
      else if (upCnt_r != 3'h7)
         upCnt_r <= upCnt_r + 3'h1;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   a_carrier_follow: assert property (
      upCnt_r > 3'h3 |-> macCarrierOn == $past(crs, 3))
      else $error("carrier level late or wrong");
   a_carrier_chg: assert property (
      upCnt_r != 3'h0 |-> macCarrierChg == $changed(macCarrierOn))
      else $error("carrier change pulse wrong");
   a_signal_follow: assert property (
      upCnt_r > 3'h3 |-> macSignalErr == $past(col, 3))
      else $error("signal level late or wrong");
   a_signal_chg: assert property (
      upCnt_r != 3'h0 |-> macSignalChg == $changed(macSignalErr))
      else $error("signal change pulse wrong");
   a_dvalid_chg: assert property (
      upCnt_r != 3'h0 |-> macDataValidChg == $changed(macDataValid))
      else $error("data valid change pulse wrong");
   a_gtx_toggle: assert property (
      upCnt_r > 3'h5 |-> gtxClk != $past(gtxClk, GTX_HALF))
      else $error("transmit clock half period wrong");
   a_tx_edges: assert property (
      $changed({txEn, txEr, txd}) |-> $fell(gtxClk))
      else $error("transmit pins moved off falling edge");
   a_ext_codes: assert property (
      txEr && !txEn |-> txd == grm_pkg::CODE_EXTEND
         || txd == grm_pkg::CODE_EXTEND_ERR)
      else $error("reserved transmit code driven");
   a_accept_once: assert property (
      macTxAccept |=> !macTxAccept)
      else $error("accept longer than one cycle");
   a_rx_single: assert property (
      !(macRxBitStb && macRxExtend))
      else $error("data and extend together");
   // Main scenarios reached
   cover property (macCarrierChg);
   cover property (macRxExtend);
   cover property (txEr && txEn);
endmodule

bind grm_top grm_props #(.GTX_HALF(GTX_HALF)) u_props (
   .clk_sys(clk_sys), .rst_n(rst_n), .crs(crs), .col(col),
   .macCarrierOn(macCarrierOn), .macCarrierChg(macCarrierChg),
   .macSignalErr(macSignalErr), .macSignalChg(macSignalChg),
   .macDataValid(macDataValid), .macDataValidChg(macDataValidChg),
   .macRxBitStb(macRxBitStb), .macRxExtend(macRxExtend),
   .macTxAccept(macTxAccept), .gtxClk(gtxClk), .txEn(txEn),
   .txEr(txEr), .txd(txd));

// file: verification/grm_phy_model.sv
module grm_phy_model (
   // Receive pins toward the sublayer
   output logic rxClk,
   output logic rxDv,
   output logic rxEr,
   output logic [7:0] rxd,
   // Transmit pins from the sublayer
   input wire logic gtxClk,
   input wire logic txEn,
   input wire logic txEr,
   input wire logic [7:0] txd
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [9:0] rxQ[$]; // Queued {dv, er, octet}, one per cycle
   logic [9:0] txCap[$]; // Captured {en, er, octet} while active
   // Continuous clock, never stretched
   initial
   begin
      rxClk = 1'b0;
      #7;
      forever #62.5 rxClk = ~rxClk;
   end
   // Lines move after the falling edge; idle data inverts
   initial
   begin
      {rxDv, rxEr, rxd} = 10'h000;
      forever
      begin
         @(negedge rxClk);
         if (rxQ.size() != 0)
            {rxDv, rxEr, rxd} = rxQ.pop_front();
         else
            {rxDv, rxEr, rxd} = {2'h0, ~rxd};
      end
   end
   // Sample transmit lines on the rising edge
   always @(posedge gtxClk)
      if (txEn || txEr)
         txCap.push_back({txEn, txEr, txd});
endmodule

// file: verification/test_gmii_reconciliation_mapping.sv
module test_gmii_reconciliation_mapping;
   timeunit 1ns;
   timeprecision 100ps;
   // Design inputs
   logic clk_sys = 1'b0, rst_n = 1'b0, ce = 1'b1, crs = 1'b0, col = 1'b0;
   logic macTxValid = 1'b0, macTxErr = 1'b0, macTxExt = 1'b0;
   logic macTxExtErr = 1'b0;
   logic [7:0] macTxData = 8'h00;
   // Design outputs and link wires
   logic macTxAccept, macRxBitStb, macRxExtend, macRxFrameErr;
   logic macRxFalseCarrier, macDataValid, macDataValidChg, macCarrierOn;
   logic macCarrierChg, macSignalErr, macSignalChg, gtxClk, txEn, txEr;
   logic rxClk, rxDv, rxEr;
   logic [7:0] macRxBits, txd, rxd;
   // Observed results and counters
   logic [7:0] rxLog[$];
   int extCnt, fcCnt, dvChg, carChg, sigChg, cyc, err_total, checks_done;
   logic feSeen, dvSeen;
   grm_top #(.GTX_HALF(2)) DUT (.clk_sys(clk_sys), .rst_n(rst_n),
      .ce(ce), .macTxValid(macTxValid), .macTxData(macTxData),
      .macTxErr(macTxErr), .macTxExt(macTxExt),
      .macTxExtErr(macTxExtErr), .macTxAccept(macTxAccept),
      .macRxBitStb(macRxBitStb), .macRxBits(macRxBits),
      .macRxExtend(macRxExtend), .macRxFrameErr(macRxFrameErr),
      .macRxFalseCarrier(macRxFalseCarrier), .macDataValid(macDataValid),
      .macDataValidChg(macDataValidChg), .macCarrierOn(macCarrierOn),
      .macCarrierChg(macCarrierChg), .macSignalErr(macSignalErr),
      .macSignalChg(macSignalChg), .gtxClk(gtxClk), .txEn(txEn),
      .txEr(txEr), .txd(txd), .rxClk(rxClk), .rxDv(rxDv), .rxEr(rxEr),
      .rxd(rxd), .crs(crs), .col(col));
   grm_phy_model phy (.rxClk(rxClk), .rxDv(rxDv), .rxEr(rxEr), .rxd(rxd),
      .gtxClk(gtxClk), .txEn(txEn), .txEr(txEr), .txd(txd));
   // 50 MHz system clock
   initial
   begin
      forever #10 clk_sys = ~clk_sys;
   end
   // Collect pulses and cut a hang short
   always @(negedge clk_sys)
   begin
      cyc++;
      if (macDataValid === 1'b1) dvSeen = 1'b1;
      if (macRxBitStb === 1'b1) rxLog.push_back(macRxBits);
      if (macRxExtend === 1'b1) extCnt++;
      if (macRxFalseCarrier === 1'b1) fcCnt++;
      if (macDataValidChg === 1'b1) dvChg++;
      if (macCarrierChg === 1'b1) carChg++;
      if (macSignalChg === 1'b1) sigChg++;
      if (macRxFrameErr === 1'b1) feSeen = 1'b1;
      if (cyc == 30000)
      begin
         err_total++;
         print_verdict();
      end
   end
   task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
      checks_done++;
      if (got !== exp)
      begin
         err_total++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic rx_clear;
      rxLog.delete();
      {extCnt, fcCnt, dvChg} = '0;
      feSeen = 1'b0;
      dvSeen = 1'b0;
   endtask
   // Wait until the model has sent its queue, then let results land
   task automatic rx_wait;
      for (int n = 0; n < 400 && phy.rxQ.size() != 0; n++)
         @(negedge clk_sys);
      repeat (40) @(negedge clk_sys);
   endtask
   task automatic t_status;
      {carChg, sigChg} = '0;
      @(negedge clk_sys) crs = 1'b1;
      repeat (6) @(negedge clk_sys);
      chk("carrier", 1, macCarrierOn);
      col = 1'b1;
      repeat (6) @(negedge clk_sys);
      chk("signal", 1, macSignalErr);
      {crs, col} = 2'b00;
      repeat (6) @(negedge clk_sys);
      chk("carrier changes", 2, carChg);
      chk("signal changes", 2, sigChg);
      $display("t_status done");
   endtask
   task automatic t_rx;
      rx_clear();
      phy.rxQ = '{10'h2a5, 10'h23c, 10'h2ff};
      rx_wait();
      chk("octets", 3, rxLog.size());
      chk("octet0", 8'ha5, rxLog[0]);
      chk("octet2", 8'hff, rxLog[2]);
      chk("valid changes", 2, dvChg);
      chk("valid level", 1, dvSeen);
      rx_clear();
      phy.rxQ = '{10'h10e, 10'h100, 10'h105, 10'h201, 10'h10f, 10'h10f};
      rx_wait();
      chk("false carrier", 1, fcCnt);
      chk("extends", 2, extCnt);
      chk("ext octets", 1, rxLog.size());
      chk("ext valid chg", 2, dvChg);
      chk("clean frame", 0, feSeen);
      $display("t_rx done");
   endtask
   task automatic t_rx_err;
      rx_clear();
      phy.rxQ = '{10'h211, 10'h322, 10'h233};
      rx_wait();
      chk("frame error", 1, feSeen);
      chk("before error", 8'h11, rxLog[0]);
      chk("after error", 8'hcc, rxLog[2]);
      rx_clear();
      phy.rxQ = '{10'h244, 10'h10f, 10'h11f, 10'h10f};
      rx_wait();
      chk("ext error", 1, feSeen);
      chk("ext before err", 1, extCnt);
      chk("data after err", 3, rxLog.size());
      chk("ext err data", 8'he0, rxLog[1]);
      $display("t_rx_err done");
   endtask
   // Hold a request until accepted or 40 cycles pass, then change it on the next cycle
   task automatic tx_req(logic v, logic [7:0] d, logic e, logic x,
         logic xe, output logic got);
      @(negedge clk_sys);
      {macTxValid, macTxData, macTxErr, macTxExt, macTxExtErr} =
         {v, d, e, x, xe};
      got = 1'b0;
      for (int n = 0; n < 40 && !got; n++)
         @(posedge clk_sys) #1 got = (macTxAccept === 1'b1);
   endtask
   task automatic t_tx;
      logic g;
      phy.txCap.delete();
      tx_req(1'b1, 8'h55, 1'b0, 1'b0, 1'b0, g);
      chk("accept", 1, g);
      tx_req(1'b1, 8'hd5, 1'b1, 1'b0, 1'b0, g);
      tx_req(1'b0, 8'h00, 1'b0, 1'b1, 1'b0, g);
      tx_req(1'b0, 8'h00, 1'b0, 1'b1, 1'b1, g);
      tx_req(1'b1, 8'h5a, 1'b0, 1'b0, 1'b0, g);
      tx_req(1'b0, 8'h00, 1'b0, 1'b0, 1'b0, g);
      repeat (20) @(negedge clk_sys);
      chk("tx count", 5, phy.txCap.size());
      chk("burst", 10'h25a, phy.txCap[4]);
      chk("preamble", 10'h255, phy.txCap[0]);
      chk("tx error", 10'h3d5, phy.txCap[1]);
      chk("extend", 10'h10f, phy.txCap[2]);
      chk("extend err", 10'h11f, phy.txCap[3]);
      chk("enable low", 0, txEn);
      tx_req(1'b0, 8'h00, 1'b0, 1'b1, 1'b0, g);
      chk("idle extend", 0, g);
      @(negedge clk_sys) macTxExt = 1'b0;
      $display("t_tx done");
   endtask
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   // Main sequence
   initial
   begin
      repeat (6) @(negedge clk_sys);
      rst_n = 1'b1;
      t_status();
      t_rx();
      t_rx_err();
      t_tx();
      print_verdict();
   end
endmodule
